// file: src/isl_pkg.sv
// constants for the interrupt source logic
// Functional notes
// - external lines detect edges only
// - edge select one rising, zero falling
// - selected edge sets the line flag
// - cleared enable blocks line request
// - flag holds until software clears it
// - enabled line edge wakes idle processor
// - after wake vector when global enabled
// - lines one, two priority in third control
// - line zero always high priority
// - eight-bit mode flags FFh to 00h wrap
// - sixteen-bit mode flags FFFFh to 0000h wrap
// - timer request gated by timer enable
// - timer priority bit in second control
// - enabled port change sets shared flag
// - port flag request gated by its enable
// - per-pin change enable bits gate pins
// - port change priority in second control
// - compare pins with value latched on read
// - output pins excluded from change compare
package isl_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CORE = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_CTRL3 = 8'h08;
    localparam logic [7:0] OFS_TCON = 8'h0c;
    localparam logic [7:0] OFS_TLOW = 8'h10;
    localparam logic [7:0] OFS_THIGH = 8'h14;
    localparam logic [7:0] OFS_IOC_A = 8'h18;
    localparam logic [7:0] OFS_IOC_B = 8'h1c;
    localparam logic [7:0] OFS_BANK_A = 8'h20;
    localparam logic [7:0] OFS_BANK_B = 8'h24;
    localparam logic [7:0] OFS_PRI2 = 8'h28;
    localparam logic [7:0] OFS_EN2 = 8'h2c;
    localparam logic [7:0] OFS_FLG2 = 8'h30;
    // ----------------------------------------
    // core control fields
    // ----------------------------------------
    localparam int B_GIEH = 7;
    localparam int B_GIEL = 6;
    localparam int B_T0E = 5;
    localparam int B_X0E = 4;
    localparam int B_PCE = 3;
    localparam int B_T0F = 2;
    localparam int B_X0F = 1;
    localparam int B_PCF = 0;
    // second control fields
    localparam int B_EDG0 = 6;
    localparam int B_EDG1 = 5;
    localparam int B_EDG2 = 4;
    localparam int B_T0P = 2;
    localparam int B_PCP = 0;
    // third control fields
    localparam int B_X2P = 7;
    localparam int B_X1P = 6;
    localparam int B_X2E = 4;
    localparam int B_X1E = 3;
    localparam int B_X2F = 1;
    localparam int B_X1F = 0;
    // timer control fields
    localparam int B_TON = 7;
    localparam int B_T8 = 6;
    // ----------------------------------------
    // widths, masks and reset values
    // ----------------------------------------
    localparam int BANK_A_W = 6;
    localparam int BANK_B_W = 8;
    localparam int SYNC_W = 3 + BANK_A_W + BANK_B_W;
    localparam logic [7:0] CORE_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h75;
    localparam logic [7:0] CTRL3_RST = 8'hc0;
    localparam logic [7:0] TCON_RST = 8'h40;
    localparam logic [7:0] PRI2_RST = 8'hfa;
    localparam logic [7:0] SEC_MASK = 8'hfa;
    localparam logic [7:0] CTRL2_MASK = 8'h75;
    localparam logic [7:0] CTRL3_MASK = 8'hdb;
    localparam logic [7:0] TCON_MASK = 8'hc0;
endpackage : isl_pkg

// file: src/isl_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module isl_pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // pins
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    // ----------------------------------------
    // stages
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // accept a change once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= '0;
        end else if (ce) begin
            level <= (s2_q & ~(s2_q ^ s3_q)) | (level & (s2_q ^ s3_q));
        end
    end
endmodule : isl_pin_sync

// file: src/isl_top.sv
// interrupt source logic with apb register access
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module isl_top
    import isl_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic ext_irq_line_0,
    input wire logic ext_irq_line_1,
    input wire logic ext_irq_line_2,
    input wire logic [isl_pkg::BANK_A_W-1:0] first_io_bank,
    input wire logic [isl_pkg::BANK_B_W-1:0] second_io_bank,
    input wire logic [isl_pkg::BANK_A_W-1:0] first_bank_is_input,
    input wire logic [isl_pkg::BANK_B_W-1:0] second_bank_is_input,
    // peripheral events and power state
    input wire logic [7:0] periph_event,
    input wire logic cpu_asleep,
    // requests to the core
    output logic irq_high,
    output logic irq_low,
    output logic cpu_wake
);
    import isl_pkg::*;

    function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
        sel = (a == o);
    endfunction : sel

    logic [7:0] core_interrupt_control_q;
    logic [7:0] second_irq_control_q;
    logic [7:0] third_irq_control_q;
    logic [7:0] tcon_q;
    logic [15:0] timer_zero_count_q;
    logic [7:0] first_port_change_enables_q;
    logic [7:0] second_port_change_enables_q;
    logic [BANK_A_W-1:0] old_a_q;
    logic [BANK_B_W-1:0] old_b_q;
    logic [7:0] secondary_priority_bits_q;
    logic [7:0] secondary_enable_bits_q;
    logic [7:0] secondary_flag_bits_q;
    logic [2:0] ext_prev_q;
    logic [SYNC_W-1:0] sync_level;
    logic [2:0] ext_lvl;
    logic [2:0] edge_sel;
    logic [2:0] ext_hit;
    logic [BANK_A_W-1:0] lvl_a;
    logic [BANK_B_W-1:0] lvl_b;
    logic [BANK_A_W+BANK_B_W-1:0] mismatch;
    logic port_change;
    logic t0_wrap;
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic [7:0] rd_mux;
    logic [5:0] req;
    logic [5:0] pri;
    logic [7:0] sec_req;
    logic any_hi;
    logic any_lo;

    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    isl_pin_sync #(.W(SYNC_W)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin({second_io_bank, first_io_bank, ext_irq_line_2, ext_irq_line_1,
              ext_irq_line_0}),
        .level(sync_level)
    );
    assign ext_lvl = sync_level[2:0];
    assign lvl_a = sync_level[3 +: BANK_A_W];
    assign lvl_b = sync_level[3+BANK_A_W +: BANK_B_W];

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign acc = psel && penable && ce;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign pready = ce;
    assign mapped = (paddr <= OFS_FLG2) && (paddr[1:0] == 2'b00);
    assign pslverr = acc && !mapped;

    always_comb begin
        rd_mux = 8'h00;
        unique case (paddr)
            OFS_CORE: rd_mux = core_interrupt_control_q;
            OFS_CTRL2: rd_mux = second_irq_control_q;
            OFS_CTRL3: rd_mux = third_irq_control_q;
            OFS_TCON: rd_mux = tcon_q;
            OFS_TLOW: rd_mux = timer_zero_count_q[7:0];
            OFS_THIGH: rd_mux = timer_zero_count_q[15:8];
            OFS_IOC_A: rd_mux = first_port_change_enables_q;
            OFS_IOC_B: rd_mux = second_port_change_enables_q;
            OFS_BANK_A: rd_mux = {2'b00, lvl_a};
            OFS_BANK_B: rd_mux = lvl_b;
            OFS_PRI2: rd_mux = secondary_priority_bits_q;
            OFS_EN2: rd_mux = secondary_enable_bits_q;
            OFS_FLG2: rd_mux = secondary_flag_bits_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= {24'h00_0000, rd_mux};
        end
    end

    // ----------------------------------------
    // external line edge detection
    // ----------------------------------------
    assign edge_sel = {second_irq_control_q[B_EDG2], second_irq_control_q[B_EDG1],
                       second_irq_control_q[B_EDG0]};
    // rising when select is one, falling otherwise
    assign ext_hit = (edge_sel & ext_lvl & ~ext_prev_q)
                   | (~edge_sel & ~ext_lvl & ext_prev_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_q <= 3'b000;
        end else if (ce) begin
            ext_prev_q <= ext_lvl;
        end
    end

    // ----------------------------------------
    // port change detection
    // ----------------------------------------
    assign mismatch = ({lvl_b, lvl_a} ^ {old_b_q, old_a_q})
                    & {second_port_change_enables_q[BANK_B_W-1:0],
                       first_port_change_enables_q[BANK_A_W-1:0]}
                    & {second_bank_is_input, first_bank_is_input};
    assign port_change = |mismatch;

    // reading a bank latches its present level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            old_a_q <= '0;
            old_b_q <= '0;
        end else begin
            if (rd && sel(paddr, OFS_BANK_A)) begin
                old_a_q <= lvl_a;
            end
            if (rd && sel(paddr, OFS_BANK_B)) begin
                old_b_q <= lvl_b;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_port_change_enables_q <= 8'h00;
            second_port_change_enables_q <= 8'h00;
        end else if (wr) begin
            if (sel(paddr, OFS_IOC_A)) begin
                first_port_change_enables_q <= {2'b00, pwdata[BANK_A_W-1:0]};
            end
            if (sel(paddr, OFS_IOC_B)) begin
                second_port_change_enables_q <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // timer zero
    // ----------------------------------------
    assign t0_wrap = ce && tcon_q[B_TON]
                   && !(wr && (sel(paddr, OFS_TLOW) || sel(paddr, OFS_THIGH)))
                   && (tcon_q[B_T8]
                   ? (timer_zero_count_q[7:0] == 8'hff)
                   : (timer_zero_count_q == 16'hffff));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcon_q <= TCON_RST;
        end else if (wr && sel(paddr, OFS_TCON)) begin
            tcon_q <= pwdata[7:0] & TCON_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_zero_count_q <= 16'h0000;
        end else if (wr && sel(paddr, OFS_TLOW)) begin
            timer_zero_count_q[7:0] <= pwdata[7:0];
        end else if (wr && sel(paddr, OFS_THIGH)) begin
            timer_zero_count_q[15:8] <= pwdata[7:0];
        end else if (ce && tcon_q[B_TON]) begin
            if (tcon_q[B_T8]) begin
                timer_zero_count_q[7:0] <= timer_zero_count_q[7:0] + 8'h01;
            end else begin
                timer_zero_count_q <= timer_zero_count_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // control and flag registers
    // ----------------------------------------
    // hardware set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_interrupt_control_q <= CORE_RST;
        end else if (ce) begin
            if (wr && sel(paddr, OFS_CORE)) begin
                core_interrupt_control_q <= pwdata[7:0];
            end
            if (t0_wrap) begin
                core_interrupt_control_q[B_T0F] <= 1'b1;
            end
            if (ext_hit[0]) begin
                core_interrupt_control_q[B_X0F] <= 1'b1;
            end
            if (port_change) begin
                core_interrupt_control_q[B_PCF] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_irq_control_q <= CTRL2_RST;
        end else if (wr && sel(paddr, OFS_CTRL2)) begin
            second_irq_control_q <= pwdata[7:0] & CTRL2_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            third_irq_control_q <= CTRL3_RST;
        end else if (ce) begin
            if (wr && sel(paddr, OFS_CTRL3)) begin
                third_irq_control_q <= pwdata[7:0] & CTRL3_MASK;
            end
            if (ext_hit[1]) begin
                third_irq_control_q[B_X1F] <= 1'b1;
            end
            if (ext_hit[2]) begin
                third_irq_control_q[B_X2F] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secondary_priority_bits_q <= PRI2_RST;
            secondary_enable_bits_q <= 8'h00;
            secondary_flag_bits_q <= 8'h00;
        end else if (ce) begin
            if (wr && sel(paddr, OFS_PRI2)) begin
                secondary_priority_bits_q <= pwdata[7:0] & SEC_MASK;
            end
            if (wr && sel(paddr, OFS_EN2)) begin
                secondary_enable_bits_q <= pwdata[7:0] & SEC_MASK;
            end
            secondary_flag_bits_q <= ((wr && sel(paddr, OFS_FLG2))
                                      ? pwdata[7:0] : secondary_flag_bits_q)
                                   & SEC_MASK | (periph_event & SEC_MASK);
        end
    end

    // ----------------------------------------
    // request and priority
    // ----------------------------------------
    // order: line0, line1, line2, timer, port change, secondary
    assign req[0] = core_interrupt_control_q[B_X0F] && core_interrupt_control_q[B_X0E];
    assign req[1] = third_irq_control_q[B_X1F] && third_irq_control_q[B_X1E];
    assign req[2] = third_irq_control_q[B_X2F] && third_irq_control_q[B_X2E];
    assign req[3] = core_interrupt_control_q[B_T0F] && core_interrupt_control_q[B_T0E];
    assign req[4] = core_interrupt_control_q[B_PCF] && core_interrupt_control_q[B_PCE];
    assign req[5] = |sec_req;
    assign sec_req = secondary_flag_bits_q & secondary_enable_bits_q;

    assign pri[0] = 1'b1;
    assign pri[1] = third_irq_control_q[B_X1P];
    assign pri[2] = third_irq_control_q[B_X2P];
    assign pri[3] = second_irq_control_q[B_T0P];
    assign pri[4] = second_irq_control_q[B_PCP];
    assign pri[5] = |(sec_req & secondary_priority_bits_q);

    assign any_hi = |(req[4:0] & pri[4:0]) || pri[5];
    assign any_lo = |(req[4:0] & ~pri[4:0]) || |(sec_req & ~secondary_priority_bits_q);

    // vector on the request when GIEH is set; low requests also need GIEL
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_high <= 1'b0;
            irq_low <= 1'b0;
            cpu_wake <= 1'b0;
        end else if (ce) begin
            irq_high <= any_hi && core_interrupt_control_q[B_GIEH];
            irq_low <= any_lo && core_interrupt_control_q[B_GIEH]
                    && core_interrupt_control_q[B_GIEL];
            cpu_wake <= cpu_asleep && |req;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_ext0_hit;
        ce && ext_hit[0];
    endsequence

    sequence s_x0_armed;
        s_ext0_hit ##1 ce && core_interrupt_control_q[B_X0E] && core_interrupt_control_q[B_GIEH];
    endsequence

    a_ext0_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_ext0_hit |=> core_interrupt_control_q[B_X0F])
        else $error("line zero edge did not set its flag");

    a_edge_rise_only: assert property (@(posedge pclk) disable iff (!presetn)
        ext_hit[1] && second_irq_control_q[B_EDG1] |-> ext_lvl[1] && !ext_prev_q[1])
        else $error("line one hit without selected rising edge");

    a_level_no_hit: assert property (@(posedge pclk) disable iff (!presetn)
        ext_lvl == ext_prev_q |-> ext_hit == 3'b000)
        else $error("steady line level caused a hit");

    a_ext0_vector: assert property (@(posedge pclk) disable iff (!presetn)
        s_x0_armed |=> irq_high)
        else $error("line zero request not taken as high priority");

    a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !third_irq_control_q[B_X1E] && !third_irq_control_q[B_X2E]
        && !core_interrupt_control_q[B_X0E] |-> req[2:0] == 3'b000)
        else $error("disabled external line raised a request");

    a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
        third_irq_control_q[B_X1F] && !(wr && sel(paddr, OFS_CTRL3))
        |=> third_irq_control_q[B_X1F])
        else $error("line one flag dropped without software write");

    a_t0_eight_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        ce && tcon_q[B_TON] && tcon_q[B_T8] && timer_zero_count_q[7:0] == 8'hff && !wr
        |=> core_interrupt_control_q[B_T0F] && timer_zero_count_q[7:0] == 8'h00)
        else $error("eight-bit wrap missed the timer flag");

    a_t0_sixteen_no: assert property (@(posedge pclk) disable iff (!presetn)
        !tcon_q[B_T8] && timer_zero_count_q != 16'hffff |-> !t0_wrap)
        else $error("sixteen-bit mode flagged before full wrap");

    a_port_change_set: assert property (@(posedge pclk) disable iff (!presetn)
        ce && |mismatch |=> core_interrupt_control_q[B_PCF])
        else $error("enabled pin change did not set the port flag");

    a_output_excluded: assert property (@(posedge pclk) disable iff (!presetn)
        first_bank_is_input == '0 && second_bank_is_input == '0 |-> !port_change)
        else $error("output pin took part in change compare");

    a_wake_on_req: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cpu_asleep && req[0] |=> cpu_wake)
        else $error("enabled line did not wake the processor");
endmodule : isl_top

// file: tb/isl_pin_model.sv
// pin-side model driving the interrupt lines and port pins
`timescale 1ns/1ps
module isl_pin_model (
    // clock
    input wire logic pclk,
    // requested levels
    input wire logic [2:0] line_req,
    input wire logic [13:0] bank_req,
    // pins
    output logic [2:0] line,
    output logic [13:0] bank
);
    // ----------------------------------------
    // pins move just after an edge
    // ----------------------------------------
    initial begin
        line = 3'h0;
        bank = 14'h0000;
    end
    always @(posedge pclk) begin
        line <= line_req;
        bank <= bank_req;
    end
endmodule : isl_pin_model

// file: tb/irq_source_logic_bench.sv
// self-checking bench for the interrupt source logic
`timescale 1ns/1ps
module irq_source_logic_bench;
    import isl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic irq_high, irq_low, cpu_wake, cpu_asleep;
    logic [7:0] paddr, rd, b;
    logic [31:0] pwdata, prdata;
    logic [2:0] line_req, line;
    logic [13:0] bank_req, bank, dir;
    int fails, checks_done, seed;
    logic [7:0] ra [5] = '{OFS_CORE, OFS_CTRL2, OFS_CTRL3, OFS_TCON, OFS_PRI2};
    logic [7:0] rv [5] = '{8'h00, 8'h75, 8'hc0, 8'h40, 8'hfa};
    // ----------------------------------------
    // design, pin model, clock
    // ----------------------------------------
    isl_pin_model pins (.pclk(pclk), .line_req(line_req), .bank_req(bank_req),
        .line(line), .bank(bank));
    isl_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq_line_0(line[0]), .ext_irq_line_1(line[1]), .ext_irq_line_2(line[2]),
        .first_io_bank(bank[5:0]), .second_io_bank(bank[13:6]),
        .first_bank_is_input(dir[5:0]), .second_bank_is_input(dir[13:6]),
        .periph_event(8'h00), .cpu_asleep(cpu_asleep), .irq_high(irq_high),
        .irq_low(irq_low), .cpu_wake(cpu_wake));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        finish_test();
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
        input string nm);
        apb(1'b0, a, 8'h00);
        chk(nm, e, rd & m);
    endtask : rdc
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    task automatic pin(input int i, input logic v);
        @(posedge pclk);
        line_req[i] <= v;
    endtask : pin
    task automatic bk(input logic [13:0] v);
        @(posedge pclk);
        bank_req <= v;
    endtask : bk
    task automatic xfl(input int i, input logic e);
        logic [7:0] m;
        m = (i == 0) ? 8'h02 : (8'h01 << (i - 1));
        rdc((i == 0) ? OFS_CORE : OFS_CTRL3, m, e ? m : 8'h00, "line flag");
    endtask : xfl
    task automatic clr();
        apb(1'b1, OFS_CORE, 8'h00);
        apb(1'b1, OFS_CTRL3, 8'hc0);
    endtask : clr
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, cpu_asleep, fails, checks_done} = '0;
        {paddr, pwdata, line_req, bank_req} = '0;
        dir = 14'h3fff;
        seed = 32'h6226;
        presetn = 1'b0;
        wt(16);
        presetn <= 1'b1;
        for (int k = 0; k < 5; k++) rdc(ra[k], 8'hff, rv[k], "reset value");
        apb(1'b0, 8'h34, 8'h00);
        chk("unmapped error", 8'h01, {7'h0, err});
        for (int i = 0; i < 3; i++) begin
            for (int p = 0; p < 2; p++) begin
                apb(1'b1, OFS_CTRL2, (p == 1) ? 8'h75 : (8'h75 ^ (8'h40 >> i)));
                pin(i, p == 1);
                wt(10);
                clr();
                pin(i, p == 0);
                wt(10);
                xfl(i, 1'b0);
                pin(i, p == 1);
                wt(10);
                xfl(i, 1'b1);
                wt(20);
                xfl(i, 1'b1);
                clr();
                xfl(i, 1'b0);
            end
        end
        for (int i = 0; i < 3; i++) pin(i, 1'b0);
        wt(10);
        apb(1'b1, OFS_CORE, 8'h90);
        pin(0, 1'b1);
        wt(10);
        chk("irq_high", 8'h01, {7'h0, irq_high});
        chk("irq_low", 8'h00, {7'h0, irq_low});
        apb(1'b1, OFS_CTRL3, 8'h88);
        apb(1'b1, OFS_CORE, 8'hc0);
        pin(1, 1'b1);
        wt(10);
        chk("irq_low", 8'h01, {7'h0, irq_low});
        chk("irq_high", 8'h00, {7'h0, irq_high});
        apb(1'b1, OFS_CTRL3, 8'hc9);
        wt(3);
        chk("irq_high", 8'h01, {7'h0, irq_high});
        apb(1'b1, OFS_CTRL3, 8'hc0);
        pin(2, 1'b1);
        wt(10);
        chk("irq_high", 8'h00, {7'h0, irq_high});
        xfl(2, 1'b1);
        @(posedge pclk);
        cpu_asleep <= 1'b1;
        for (int g = 1; g >= 0; g--) begin
            apb(1'b1, OFS_CORE, (g == 1) ? 8'h90 : 8'h10);
            pin(0, 1'b0);
            wt(10);
            chk("cpu_wake", 8'h00, {7'h0, cpu_wake});
            pin(0, 1'b1);
            wt(10);
            chk("cpu_wake", 8'h01, {7'h0, cpu_wake});
            chk("irq_high", g[7:0], {7'h0, irq_high});
        end
        @(posedge pclk);
        cpu_asleep <= 1'b0;
        apb(1'b1, OFS_CORE, 8'h80);
        apb(1'b1, OFS_TLOW, 8'hf0);
        apb(1'b1, OFS_TCON, 8'hc0);
        wt(30);
        rdc(OFS_CORE, 8'h04, 8'h04, "timer flag");
        chk("irq_high", 8'h00, {7'h0, irq_high});
        apb(1'b1, OFS_CTRL2, 8'h71);
        apb(1'b1, OFS_CORE, 8'he0);
        wt(270);
        chk("irq_low", 8'h01, {7'h0, irq_low});
        chk("irq_high", 8'h00, {7'h0, irq_high});
        apb(1'b1, OFS_CTRL2, 8'h75);
        for (int h = 0; h < 2; h++) begin
            apb(1'b1, OFS_TCON, 8'h00);
            apb(1'b1, OFS_THIGH, (h == 1) ? 8'hff : 8'h00);
            apb(1'b1, OFS_TLOW, 8'hf0);
            apb(1'b1, OFS_CORE, 8'h00);
            apb(1'b1, OFS_TCON, 8'h80);
            wt(30);
            rdc(OFS_CORE, 8'h04, (h == 1) ? 8'h04 : 8'h00, "wide flag");
        end
        apb(1'b1, OFS_TCON, 8'h00);
        apb(1'b1, OFS_IOC_A, 8'h01);
        apb(1'b0, OFS_BANK_A, 8'h00);
        apb(1'b1, OFS_CORE, 8'h00);
        bk(bank_req ^ 14'h0002);
        wt(10);
        rdc(OFS_CORE, 8'h01, 8'h00, "port flag");
        bk(bank_req ^ 14'h0001);
        wt(10);
        rdc(OFS_CORE, 8'h01, 8'h01, "port flag");
        apb(1'b0, OFS_BANK_A, 8'h00);
        apb(1'b1, OFS_CORE, 8'h88);
        wt(3);
        chk("irq_high", 8'h00, {7'h0, irq_high});
        bk(bank_req ^ 14'h0001);
        wt(10);
        chk("irq_high", 8'h01, {7'h0, irq_high});
        dir <= 14'h3ffb;
        apb(1'b1, OFS_IOC_A, 8'h04);
        apb(1'b0, OFS_BANK_A, 8'h00);
        apb(1'b1, OFS_CORE, 8'h00);
        bk(bank_req ^ 14'h0004);
        wt(10);
        rdc(OFS_CORE, 8'h01, 8'h00, "port flag");
        apb(1'b1, OFS_IOC_B, 8'hff);
        apb(1'b0, OFS_BANK_B, 8'h00);
        apb(1'b1, OFS_CORE, 8'h00);
        b = bank_req[13:6] ^ (8'($random(seed)) | 8'h01);
        bk({b, bank_req[5:0]});
        wt(10);
        rdc(OFS_BANK_B, 8'hff, b, "bank b level");
        rdc(OFS_CORE, 8'h01, 8'h01, "port flag");
        finish_test();
    end
endmodule : irq_source_logic_bench
